// File: core/qbt_pkg.sv
// Functional notes
// R1 - Four identical lanes, indexed zero to three.
// R2 - word_pick low picks first word, high second.
// R3 - Driver register loads on driver clock rise.
// R4 - Steady driver clock leaves register unchanged.
// R5 - Drive enable high releases all bus drivers.
// R6 - Driven bus line is complement of register.
// R7 - Drivers only pull low or release lines.
// R8 - Receivers sense the same pin as driver.
// R9 - Receiver inverts bus, path overall non-inverting.
// R10 - Latch enable low makes latches transparent.
// R11 - Latch enable high holds value at rise.
// R12 - Output enable high floats receiver outputs.
// R13 - Released drivers let others' data be received.
// R14 - Drive enable selects parity generate or check.
// R15 - Generate mode gives odd parity of selection.
// R16 - Check mode gives odd parity of latches.
// R17 - No reset for register or latch contents.
// R18 - Parameter picks three-state or parity variant.
package qbt_pkg;
	// Number of lanes in the transceiver.
	localparam int QBT_LANES = 4;
	// Variant codes for the build-time selection.
	localparam bit QBT_VAR_TRISTATE = 1'b0;
	localparam bit QBT_VAR_PARITY = 1'b1;
	// Register map of the local staging port, byte addresses.
	localparam logic [7:0] QBT_ADDR_WORDS = 8'h00;
	localparam logic [7:0] QBT_ADDR_CTRL = 8'h04;
	localparam logic [7:0] QBT_ADDR_STATUS = 8'h08;
	localparam logic [7:0] QBT_ADDR_FIFO = 8'h0c;
	// Control register fields.
	localparam int QBT_CTRL_PICK = 0;
	localparam int QBT_CTRL_BEN = 1;
	localparam int QBT_CTRL_LATCH = 2;
	localparam int QBT_CTRL_OEN = 3;
	// Control value after reset: drivers released, outputs floated, latches open.
	localparam logic [3:0] QBT_CTRL_RESET = 4'ha;
	// Write response codes.
	localparam logic [1:0] QBT_RESP_OKAY = 2'h0;
	localparam logic [1:0] QBT_RESP_SLVERR = 2'h2;
	// FIFO depth default.
	localparam int QBT_FIFO_DEPTH = 32;
endpackage

// File: core/qbt_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// Simple synchronous FIFO with valid and ready on both sides.
module qbt_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	// Storage array for the queued words.
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;
	assign in_ready = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data = mem[rd_ptr_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Storage write; data memory needs no reset.
	always_ff @(posedge aclk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end
	// Pointer and occupancy tracking.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: core/qbt_top.sv
`timescale 1ns/1ps
`default_nettype none
// Quad bus transceiver with an AXI4-Lite staging port for its local words.
// The pins of the device are mirrored as plain ports; the driver clock is
// sampled synchronously and its rising edges detected in aclk; latch enable acts as a level.
module qbt_top #(
	parameter bit VARIANT = qbt_pkg::QBT_VAR_TRISTATE,
	parameter int LANES = qbt_pkg::QBT_LANES,
	parameter int DEPTH = qbt_pkg::QBT_FIFO_DEPTH
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [LANES-1:0] first_word_in,
	input wire logic [LANES-1:0] second_word_in,
	input wire logic word_pick,
	input wire logic driver_register_clock,
	input wire logic bus_drive_enable_n,
	input wire logic receive_latch_enable,
	input wire logic receive_output_enable_n,
	input wire logic [LANES-1:0] bus_in,
	output logic [LANES-1:0] bus_out,
	output logic [LANES-1:0] bus_oe,
	output logic [LANES-1:0] latched_output,
	output logic [LANES-1:0] latched_output_oe,
	output logic parity_out
);
	import qbt_pkg::*;

	// Odd parity: high when the count of ones is even.
	function automatic logic odd_par(input logic [LANES-1:0] w);
		odd_par = ~(^w);
	endfunction

	// Software-held words and controls, used when ctrl selects staging.
	logic [LANES-1:0] sw_first_r;
	logic [LANES-1:0] sw_second_r;
	logic [3:0] ctrl_r;
	logic sw_mode_r;
	// Effective pin-level controls after the staging choice.
	logic [LANES-1:0] w_first;
	logic [LANES-1:0] w_second;
	logic pick;
	logic ben_n;
	logic latch_en; // Effective receiver latch enable, high holds.
	logic oen;
	// Previous samples for edge detection.
	logic drclk_q_r;
	logic drclk_q2_r;
	// Lane storage.
	logic [LANES-1:0] drv_reg_r;
	logic [LANES-1:0] latch_r;
	logic [LANES-1:0] sel_word;
	logic [LANES-1:0] bus_level;
	logic [LANES-1:0] rx_word;
	// FIFO of received words toward software.
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [LANES-1:0] fifo_out_data;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [LANES-1:0] last_pushed_r;
	logic rd_pop;

	// Software staging overrides the pin words and controls when enabled.
	assign w_first = sw_mode_r ? sw_first_r : first_word_in;
	assign w_second = sw_mode_r ? sw_second_r : second_word_in;
	assign pick = sw_mode_r ? ctrl_r[QBT_CTRL_PICK] : word_pick;
	assign ben_n = sw_mode_r ? ctrl_r[QBT_CTRL_BEN] : bus_drive_enable_n;
	assign latch_en = sw_mode_r ? ctrl_r[QBT_CTRL_LATCH] : receive_latch_enable;
	assign oen = sw_mode_r ? ctrl_r[QBT_CTRL_OEN] : receive_output_enable_n;

	// Per-lane selector and bus level seen at the shared pin.
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane // R1
			assign sel_word[g] = pick ? w_second[g] : w_first[g]; // R2
			// Wired-OR: our own pull-down wins over the bus's level.
			assign bus_level[g] = bus_in[g] & ~(~ben_n & drv_reg_r[g]); // R8
			assign rx_word[g] = ~bus_level[g]; // R9
		end
	endgenerate

	// Driver clock sample history for rising-edge detection.
	always_ff @(posedge aclk) begin
		drclk_q_r <= driver_register_clock;
		drclk_q2_r <= drclk_q_r;
	end

	// Driver register: loads only on a low-to-high clock step, no reset.
	always_ff @(posedge aclk) begin
		if (drclk_q_r && !drclk_q2_r) begin // R3 R4 R17
			drv_reg_r <= sel_word;
		end
	end

	// Receiver latch: follows while enable low, holds while high.
	always_ff @(posedge aclk) begin
		if (!latch_en) begin // R10 R11 R17
			latch_r <= rx_word;
		end
	end

	// Bus pins only pull low or release; high comes from the pull-up.
	always_ff @(posedge aclk) begin
		bus_out <= '0; // R7
		bus_oe <= ben_n ? '0 : drv_reg_r; // R5 R6 R7
	end

	// Receiver outputs with optional three-state control.
	always_ff @(posedge aclk) begin
		latched_output <= latch_r; // R13
		if (VARIANT == QBT_VAR_TRISTATE) begin // R18
			latched_output_oe <= oen ? '0 : '1; // R12
		end else begin
			latched_output_oe <= '1;
		end
	end

	// Parity output: generate while driving, check while released.
	always_ff @(posedge aclk) begin
		if (VARIANT == QBT_VAR_PARITY) begin // R18
			parity_out <= ben_n ? odd_par(latch_r) : odd_par(sel_word); // R14 R15 R16
		end else begin
			parity_out <= 1'b0;
		end
	end

	// Received words enter the FIFO whenever the latch content differs from the last word pushed and the FIFO is not full.
	assign fifo_in_valid = (latch_r != last_pushed_r);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_pushed_r <= '0;
		end else if (fifo_in_valid && fifo_in_ready) begin
			last_pushed_r <= latch_r;
		end
	end

	qbt_fifo #(.WIDTH(LANES), .DEPTH(DEPTH)) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_data(latch_r),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready)
	);
	assign fifo_out_ready = rd_pop;

	// Write channel: take address and data in either order, then respond.
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= QBT_RESP_OKAY;
			sw_first_r <= '0;
			sw_second_r <= '0;
			ctrl_r <= QBT_CTRL_RESET;
			sw_mode_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (aw_held_r && w_held_r && !s_axi_bvalid) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= QBT_RESP_OKAY;
				// Only byte lane 0 carries register bits.
				case (aw_addr_r)
					QBT_ADDR_WORDS: begin
						if (w_strb_r[0]) begin
							sw_first_r <= w_data_r[LANES-1:0];
							sw_second_r <= w_data_r[LANES+3:4];
						end
					end
					QBT_ADDR_CTRL: begin
						if (w_strb_r[0]) begin
							ctrl_r <= w_data_r[3:0];
							sw_mode_r <= w_data_r[4];
						end
					end
					default: begin
						s_axi_bresp <= QBT_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = !w_held_r && !s_axi_bvalid;

	// Read channel: one-cycle answer; the FIFO register pops on read.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= QBT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= QBT_RESP_OKAY;
			case (s_axi_araddr)
				QBT_ADDR_WORDS: s_axi_rdata <= {24'h0, sw_second_r, sw_first_r};
				QBT_ADDR_CTRL: s_axi_rdata <= {27'h0, sw_mode_r, ctrl_r};
				QBT_ADDR_STATUS: s_axi_rdata <= {22'h0, fifo_out_valid, !fifo_in_ready,
					drv_reg_r, latch_r};
				QBT_ADDR_FIFO: s_axi_rdata <= {27'h0, fifo_out_valid, fifo_out_data};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= QBT_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_pop = s_axi_arvalid && s_axi_arready && (s_axi_araddr == QBT_ADDR_FIFO)
		&& fifo_out_valid;
endmodule
`default_nettype wire

// File: sim/qbt_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Pin-side checks of the transceiver, bound to its top module.
module qbt_checker #(
	parameter bit VARIANT = 1'h0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] first_word_in,
	input wire logic [3:0] second_word_in,
	input wire logic word_pick,
	input wire logic bus_drive_enable_n,
	input wire logic receive_latch_enable,
	input wire logic [3:0] bus_in,
	input wire logic [3:0] bus_out,
	input wire logic [3:0] bus_oe,
	input wire logic [3:0] latched_output,
	input wire logic [3:0] latched_output_oe,
	input wire logic parity_out
);
	logic [3:0] sel_w; // Word that the selector passes on.
	logic open_idle; // Drivers released and latches open.
	assign sel_w = word_pick ? second_word_in : first_word_in;
	assign open_idle = bus_drive_enable_n && !receive_latch_enable;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	pull_low_a: assert property (bus_out == 4'h0)
		else $error("bus data not low");
	drive_release_a: assert property (bus_drive_enable_n |=> bus_oe == 4'h0)
		else $error("bus driven while released");
	own_echo_a: assert property ((!bus_drive_enable_n && !receive_latch_enable
		&& $stable(bus_oe))[*4] |-> (bus_oe & ~latched_output) == 4'h0)
		else $error("own word not received");
	hold_latch_a: assert property (receive_latch_enable[*4] |-> $stable(latched_output))
		else $error("closed latch moved");
	follow_bus_a: assert property ((open_idle && $stable(bus_in))[*4]
		|-> latched_output == ~bus_in)
		else $error("open latch not following");
	out_on_a: assert property (VARIANT |-> latched_output_oe == 4'hf)
		else $error("outputs not driven");
	gen_parity_a: assert property ((VARIANT && !bus_drive_enable_n)[*2]
		|=> parity_out == ~^$past(sel_w))
		else $error("generated parity wrong");
	check_parity_a: assert property ((VARIANT && bus_drive_enable_n)[*2]
		|-> parity_out == ~^latched_output)
		else $error("checked parity wrong");
	cover property (!bus_drive_enable_n ##1 bus_oe != 4'h0);
	cover property (receive_latch_enable[*4]);
	cover property (bus_drive_enable_n && parity_out);
endmodule
bind qbt_top qbt_checker #(.VARIANT(VARIANT)) qbt_checker_i (.aclk(aclk), .aresetn(aresetn),
	.first_word_in(first_word_in), .second_word_in(second_word_in), .word_pick(word_pick),
	.bus_drive_enable_n(bus_drive_enable_n), .receive_latch_enable(receive_latch_enable),
	.bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe), .latched_output(latched_output),
	.latched_output_oe(latched_output_oe), .parity_out(parity_out));
`default_nettype wire

// File: sim/qbt_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// Other transceivers and the pull-up sharing the four bus lines.
module qbt_bus_model (
	input wire logic [3:0] dut_oe,
	input wire logic [3:0] other_pull,
	output logic [3:0] bus_level
);
	// A line is low while any party pulls it, else the pull-up holds it high.
	assign bus_level = ~(dut_oe | other_pull);
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
// Parity build of the transceiver on a bus shared with other pullers.
module tb;
	import qbt_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] adr = 8'h00;
	logic awv = 1'h0, wv = 1'h0, brdy = 1'h0, arv = 1'h0, rrdy = 1'h0;
	logic awr, wrd, bvld, arr, rvld, par;
	logic [1:0] br, rr, r;
	logic [31:0] rdat, d;
	logic [3:0] fw = 4'h0, sw = 4'h0, op = 4'h0;
	logic pick = 1'h0, drc = 1'h0, ben_n = 1'h1, latch_en = 1'h0;
	logic [31:0] wd = 32'h0;
	logic [3:0] bus, bo, oe, lat, lat_oe;
	int failures = 0;
	int n_checks = 0;
	always #5 aclk = ~aclk;
	qbt_top #(.VARIANT(QBT_VAR_PARITY)) qbt_top_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(adr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
		.s_axi_bvalid(bvld), .s_axi_bready(brdy), .s_axi_araddr(adr), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rvld),
		.s_axi_rready(rrdy), .first_word_in(fw), .second_word_in(sw), .word_pick(pick),
		.driver_register_clock(drc), .bus_drive_enable_n(ben_n), .receive_latch_enable(latch_en),
		.receive_output_enable_n(1'h0), .bus_in(bus), .bus_out(bo), .bus_oe(oe),
		.latched_output(lat), .latched_output_oe(lat_oe), .parity_out(par));
	qbt_bus_model qbt_bus_model_i (.dut_oe(oe), .other_pull(op), .bus_level(bus));
	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	// Lets n edges pass, then stops mid-cycle where outputs are settled.
	task automatic look(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask
	// One register access; each channel is released when it is taken.
	task automatic acc(input logic w, input logic [7:0] a);
		logic ta, tw, tk;
		@(posedge aclk);
		adr <= a;
		{awv, wv, brdy, arv, rrdy} <= {w, w, w, !w, !w};
		do begin
			@(negedge aclk);
			ta = (awv && awr) || (arv && arr);
			tw = wv && wrd;
			tk = w ? bvld : rvld;
			d = rdat;
			r = w ? br : rr;
			@(posedge aclk);
			if (ta) {awv, arv} <= 2'h0;
			if (tw) wv <= 1'h0;
		end while (!tk);
		{brdy, rrdy} <= 2'h0;
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		#100000;
		failures++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		acc(1'h0, QBT_ADDR_CTRL);
		chk(d, 32'(QBT_CTRL_RESET));
		acc(1'h0, 8'h10);
		chk(32'(r), 32'(QBT_RESP_SLVERR));
		acc(1'h1, 8'h10);
		chk(32'(r), 32'(QBT_RESP_SLVERR));
		// Other pullers toggle the bus so the buffer fills, then it drains.
		for (int j = 0; j < 34; j++) begin
			@(posedge aclk);
			op <= j[0] ? 4'h2 : 4'h1;
			look(2);
		end
		acc(1'h0, QBT_ADDR_STATUS);
		chk(32'(d[8]), 32'h1);
		for (int j = 0; j < 32; j++) begin
			acc(1'h0, QBT_ADDR_FIFO);
			chk(d, {27'h0, 1'h1, j[0] ? 4'h2 : 4'h1});
		end
		acc(1'h0, QBT_ADDR_FIFO);
		chk(32'(d[4]), 32'h0);
		// Driver register loads on the rising edge only.
		@(posedge aclk);
		{op, fw, sw, drc} <= {4'h0, 4'h5, 4'ha, 1'h1};
		look(4);
		@(posedge aclk);
		{drc, fw} <= {1'h0, 4'h3};
		look(4);
		acc(1'h0, QBT_ADDR_STATUS);
		chk(32'(d[7:4]), 32'h5);
		@(posedge aclk);
		{pick, drc} <= 2'h3;
		look(4);
		acc(1'h0, QBT_ADDR_STATUS);
		chk(32'(d[7:4]), 32'ha);
		@(posedge aclk);
		ben_n <= 1'h0;
		look(4);
		chk(32'(oe), 32'ha);
		chk(32'(lat), 32'ha);
		chk(32'(par), 32'(~^4'ha));
		@(posedge aclk);
		{fw, pick} <= {4'h7, 1'h0};
		look(3);
		chk(32'(par), 32'(~^4'h7));
		@(posedge aclk);
		ben_n <= 1'h1;
		look(4);
		chk(32'(oe), 32'h0);
		chk(32'(par), 32'(~^4'h0));
		@(posedge aclk);
		op <= 4'h7;
		look(4);
		chk(32'(lat), 32'h7);
		chk(32'(par), 32'(~^4'h7));
		@(posedge aclk);
		latch_en <= 1'h1;
		look(3);
		@(posedge aclk);
		op <= 4'h1;
		look(4);
		chk(32'(lat), 32'h7);
		@(posedge aclk);
		latch_en <= 1'h0;
		look(4);
		chk(32'(lat), 32'h1);
		chk(32'(lat_oe), 32'hf);
		// Staged words and controls stand in for the pins once staging is on.
		@(posedge aclk);
		{drc, wd} <= {1'h0, 32'h69};
		acc(1'h1, QBT_ADDR_WORDS);
		chk(32'(r), 32'(QBT_RESP_OKAY));
		acc(1'h0, QBT_ADDR_WORDS);
		chk(d, 32'h69);
		wd <= 32'h13;
		acc(1'h1, QBT_ADDR_CTRL);
		chk(32'(r), 32'(QBT_RESP_OKAY));
		acc(1'h0, QBT_ADDR_CTRL);
		chk(d, 32'h13);
		@(posedge aclk);
		drc <= 1'h1;
		look(4);
		acc(1'h0, QBT_ADDR_STATUS);
		chk(32'(d[7:4]), 32'h6);
		conclude();
	end
endmodule
`default_nettype wire
